// [inc/cpl_pkg.sv]
// Shared constants and carrier types for the code protection lock
package cpl_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] CPL_ERASE_ADDR = 8'h94;
   localparam logic [7:0] CPL_FLCTL_ADDR = 8'hb2;
   localparam logic [7:0] CPL_PGSEL_ADDR = 8'hb7;
   localparam logic [15:0] CPL_CFG1_ADDR = 16'h2005;

   // ------------------------------------------------------------
   // Field positions, masks, reset values
   // ------------------------------------------------------------
   localparam int CPL_BOOT_BIT = 7;
   localparam int CPL_LOCK_BIT = 6;
   localparam int CPL_ARM_BIT = 1;
   localparam int CPL_PWE_BIT = 0;
   localparam int CPL_DCLK_OFF_BIT = 5;
   localparam int CPL_PGSEL_LSB = 1;
   localparam logic [7:0] CPL_CFG1_MASK = 8'hbf;
   localparam logic [7:0] CPL_CFG1_RESET = 8'h00;
   localparam logic [6:0] CPL_PGSEL_RESET = 7'h00;
   localparam logic [6:0] CPL_PAGE_ZERO = 7'h00;
   localparam int CPL_PAGE_LSB = 9;

   // ------------------------------------------------------------
   // Commands and timing
   // ------------------------------------------------------------
   localparam logic [7:0] CPL_CMD_MASS = 8'haa;
   localparam logic [7:0] CPL_CMD_PAGE = 8'h55;
   localparam logic [5:0] CPL_BOOT_CYCLES = 6'h20;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [7:0] data;
   } cpl_wr_type;

   typedef enum logic [1:0] {
      CPL_DBG_READ,
      CPL_DBG_WRITE,
      CPL_DBG_SFR
   } cpl_dbg_op_type;

   typedef struct packed {
      logic valid;
      cpl_dbg_op_type op;
      logic [15:0] addr;
      logic [7:0] data;
   } cpl_dbg_req_type;

   typedef struct packed {
      logic rd;
      logic wr;
      logic page_erase;
      logic mass_erase;
      logic engine_program_ram_clear;
      logic [15:0] addr;
      logic [7:0] data;
      logic [6:0] page;
   } cpl_flash_cmd_type;

endpackage

// [tb/cpl_flash_model.sv]
// Behavioural flash array behind the protection lock
`timescale 1ns/1ns
module cpl_flash_model
   import cpl_pkg::*;
(
   input logic clk,
   input cpl_flash_cmd_type flash_cmd,
   output logic [7:0] flash_rdata
);
   logic [7:0] mem [logic [15:0]];
   initial flash_rdata = 8'h00;
   always @(posedge clk)
   begin
      // Toggle outside read slots so a late capture fails
      flash_rdata <= ~flash_rdata;
      if (flash_cmd.rd === 1'b1)
         flash_rdata <= mem.exists(flash_cmd.addr) ? mem[flash_cmd.addr] : 8'hff;
      if (flash_cmd.wr === 1'b1)
         mem[flash_cmd.addr] = flash_cmd.data;
      if (flash_cmd.mass_erase === 1'b1)
         mem.delete();
      if (flash_cmd.page_erase === 1'b1)
         foreach (mem[a])
            if (a[15:9] == flash_cmd.page)
               mem[a] = 8'hff;
   end
endmodule // cpl_flash_model

// [tb/cpl_properties.sv]
// Assertion checker for the code protection lock ports
`timescale 1ns/1ns
module cpl_properties
   import cpl_pkg::*;
(
   input logic clk,
   input logic reset_n,
   input logic ce,
   input cpl_wr_type mpu_sfr_wr,
   input logic [7:0] mpu_sfr_rd_addr,
   input logic [7:0] mpu_sfr_rdata,
   input cpl_wr_type cfg_wr,
   input cpl_dbg_req_type dbg_req,
   input logic dbg_port_en,
   input logic dbg_refused,
   input logic dbg_clk_en,
   input cpl_flash_cmd_type flash_cmd
);
   // ------------
   // Shadow state
   // ------------
   logic [5:0] cnt_q;
   logic lock_q;
   logic dclk_q;
   logic b2_rd;
   assign b2_rd = ce && mpu_sfr_rd_addr == CPL_FLCTL_ADDR;
   // Lock shadow sees MPU sets only: it may lag, never lead
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cnt_q <= 6'h00;
         lock_q <= 1'b0;
         dclk_q <= 1'b0;
      end
      else if (ce)
      begin
         if (cnt_q != 6'h3f)
            cnt_q <= cnt_q + 6'h01;
         if (mpu_sfr_wr.valid && mpu_sfr_wr.addr[7:0] == CPL_FLCTL_ADDR && mpu_sfr_wr.data[CPL_LOCK_BIT])
            lock_q <= 1'b1;
         if (cfg_wr.valid && cfg_wr.addr == CPL_CFG1_ADDR)
            dclk_q <= cfg_wr.data[CPL_DCLK_OFF_BIT];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----------
   // Properties
   // ----------
   property p_boot_refuse;
      ce && dbg_req.valid && cnt_q < CPL_BOOT_CYCLES |=> dbg_refused;
   endproperty
   a_boot_refuse: assert property (p_boot_refuse)
      else $error("emulator served in boot window");
   property p_lock_read;
      ce && lock_q && dbg_req.valid && dbg_req.op == CPL_DBG_READ |=> dbg_refused && !flash_cmd.rd;
   endproperty
   a_lock_read: assert property (p_lock_read)
      else $error("locked read reached flash");
   property p_lock_keep;
      b2_rd && lock_q |=> mpu_sfr_rdata[6];
   endproperty
   a_lock_keep: assert property (p_lock_keep)
      else $error("lock bit dropped");
   property p_boot_flag;
      b2_rd |=> mpu_sfr_rdata[CPL_BOOT_BIT] == ($past(cnt_q) < CPL_BOOT_CYCLES);
   endproperty
   a_boot_flag: assert property (p_boot_flag)
      else $error("boot flag wrong");
   property p_unused;
      b2_rd |=> mpu_sfr_rdata[5:1] == 5'h00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused control bits not zero");
   property p_mass;
      flash_cmd.mass_erase |-> flash_cmd.engine_program_ram_clear && $past(dbg_port_en, 2);
   endproperty
   a_mass: assert property (p_mass)
      else $error("bulk erase without ram clear or port");
   property p_page0_erase;
      flash_cmd.page_erase && $past(lock_q, 2) |-> flash_cmd.page != CPL_PAGE_ZERO;
   endproperty
   a_page0_erase: assert property (p_page0_erase)
      else $error("locked page zero erased");
   property p_page0_write;
      flash_cmd.wr && $past(lock_q, 2) |-> flash_cmd.addr[15:CPL_PAGE_LSB] != CPL_PAGE_ZERO;
   endproperty
   a_page0_write: assert property (p_page0_write)
      else $error("locked page zero written");
   property p_clk_off;
      dclk_q [*3] |-> !dbg_clk_en;
   endproperty
   a_clk_off: assert property (p_clk_off)
      else $error("debug clock still running");
endmodule // cpl_properties

// [tb/cpl_top_tb.sv]
// Directed bench for the code protection lock
`timescale 1ns/1ns
module cpl_top_tb
   import cpl_pkg::*;
();
   logic clk;
   logic reset_n;
   cpl_wr_type mpu_sfr_wr;
   logic [7:0] mpu_sfr_rd_addr;
   logic [7:0] mpu_sfr_rdata;
   cpl_wr_type mpu_prog_wr;
   cpl_wr_type cfg_wr;
   logic [15:0] cfg_rd_addr;
   logic [7:0] cfg_rdata;
   cpl_dbg_req_type dbg_req;
   logic dbg_port_en;
   logic mpu_int_en;
   logic dbg_ack;
   logic dbg_refused;
   logic [7:0] dbg_rdata;
   logic dbg_clk_en;
   cpl_flash_cmd_type flash_cmd;
   logic [7:0] flash_rdata;
   int failures;
   int samples_checked;
   int n[4];
   int c;
   logic [7:0] v;
   logic [1:0] r;
   cpl_top i_dut (.clk, .reset_n, .ce(1'b1), .mpu_sfr_wr, .mpu_sfr_rd_addr, .mpu_sfr_rdata,
      .mpu_int_en, .mpu_prog_wr, .cfg_wr, .cfg_rd_addr, .cfg_rdata, .dbg_req, .dbg_port_en,
      .dbg_ack, .dbg_refused, .dbg_rdata, .dbg_clk_en, .flash_cmd, .flash_rdata);
   cpl_flash_model i_flash (.clk, .flash_cmd, .flash_rdata);
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Pulse tallies: write, page erase, bulk erase, ram clear
   always @(posedge clk)
   begin
      n[0] += (flash_cmd.wr === 1'b1);
      n[1] += (flash_cmd.page_erase === 1'b1);
      n[2] += (flash_cmd.mass_erase === 1'b1);
      n[3] += (flash_cmd.engine_program_ram_clear === 1'b1);
   end
   // -------------
   // Shared tasks
   // -------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic do_reset;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
   endtask
   // Kind 0 control register, 1 program space, 2 config
   task automatic put(input int k, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      case (k)
         0: mpu_sfr_wr <= '{1'b1, a, d};
         1: mpu_prog_wr <= '{1'b1, a, d};
         default: cfg_wr <= '{1'b1, a, d};
      endcase
      @(posedge clk);
      mpu_sfr_wr.valid <= 1'b0;
      mpu_prog_wr.valid <= 1'b0;
      cfg_wr.valid <= 1'b0;
   endtask
   task automatic rd(input int k, input logic [15:0] a);
      @(posedge clk);
      mpu_sfr_rd_addr <= a[7:0];
      cfg_rd_addr <= a;
      @(posedge clk);
      #1 v = (k == 1) ? cfg_rdata : mpu_sfr_rdata;
   endtask
   task automatic dbg(input cpl_dbg_op_type op, input logic [15:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      dbg_req <= '{1'b1, op, a, d};
      @(posedge clk);
      dbg_req.valid <= 1'b0;
      r = 2'b00;
      for (i = 0; i < 6 && r === 2'b00; i++)
      begin
         #1 r = {dbg_ack, dbg_refused};
         v = dbg_rdata;
         if (r === 2'b00)
            @(posedge clk);
      end
      if (r === 2'b00)
      begin
         failures++;
         tally_and_finish();
      end
   endtask
   task automatic seq(input logic [7:0] a, input logic [7:0] d, input logic [7:0] cmd);
      put(0, {8'h00, a}, d);
      put(0, {8'h00, CPL_ERASE_ADDR}, cmd);
      repeat (4) @(posedge clk);
   endtask
   task automatic pw(input logic [15:0] a, input logic [7:0] d);
      put(0, {8'h00, CPL_FLCTL_ADDR}, 8'h01);
      put(1, a, d);
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic t_boot;
      rd(0, {8'h00, CPL_FLCTL_ADDR});
      check("boot flag", v[7], 1'b1);
      check("lock at reset", v[6], 1'b0);
      dbg(CPL_DBG_READ, 16'h0000, 8'h00);
      check("boot emulator", r, 2'b01);
      repeat (32) @(posedge clk);
      rd(0, {8'h00, CPL_FLCTL_ADDR});
      check("boot flag end", v[7], 1'b0);
      $display("done boot");
   endtask
   task automatic t_open;
      pw(16'h0010, 8'h3c);
      dbg(CPL_DBG_READ, 16'h0010, 8'h00);
      check("open read", {r, v}, {2'b10, 8'h3c});
      c = n[1];
      seq(CPL_PGSEL_ADDR, 8'h00, CPL_CMD_PAGE);
      check("page erase", n[1] - c, 16'h0001);
      dbg(CPL_DBG_READ, 16'h0010, 8'h00);
      check("erased byte", v, 8'hff);
      c = n[2];
      put(0, {8'h00, CPL_ERASE_ADDR}, CPL_CMD_MASS);
      repeat (4) @(posedge clk);
      check("unarmed bulk", n[2] - c, 16'h0000);
      $display("done open");
   endtask
   task automatic t_lock;
      do_reset();
      put(0, {8'h00, CPL_FLCTL_ADDR}, 8'h40);
      put(0, {8'h00, CPL_FLCTL_ADDR}, 8'h00);
      rd(0, {8'h00, CPL_FLCTL_ADDR});
      check("lock sticky", v[6], 1'b1);
      repeat (32) @(posedge clk);
      dbg(CPL_DBG_READ, 16'h0010, 8'h00);
      check("locked read", r, 2'b01);
      c = n[0];
      dbg(CPL_DBG_WRITE, 16'h0300, 8'h77);
      check("locked write", r, 2'b01);
      pw(16'h0004, 8'h11);
      pw(16'h0204, 8'h22);
      repeat (2) @(posedge clk);
      check("page zero write", n[0] - c, 16'h0001);
      c = n[1];
      seq(CPL_PGSEL_ADDR, 8'h00, CPL_CMD_PAGE);
      check("page zero erase", n[1] - c, 16'h0000);
      seq(CPL_PGSEL_ADDR, 8'h02, CPL_CMD_PAGE);
      check("page one erase", n[1] - c, 16'h0001);
      c = n[2];
      dbg(CPL_DBG_SFR, {8'h00, CPL_FLCTL_ADDR}, 8'h02);
      check("locked arm", r, 2'b10);
      dbg(CPL_DBG_SFR, {8'h00, CPL_ERASE_ADDR}, CPL_CMD_MASS);
      repeat (4) @(posedge clk);
      check("locked bulk", n[2] - c, 16'h0001);
      check("ram clear", n[3] - c, 16'h0001);
      rd(0, {8'h00, CPL_FLCTL_ADDR});
      check("lock after erase", v[6], 1'b1);
      $display("done lock");
   endtask
   task automatic t_clear;
      do_reset();
      rd(1, CPL_CFG1_ADDR);
      check("config reset", v, 8'h00);
      repeat (34) @(posedge clk);
      rd(0, {8'h00, CPL_FLCTL_ADDR});
      check("lock cleared", v[6], 1'b0);
      dbg(CPL_DBG_READ, 16'h0204, 8'h00);
      check("blank read", {r, v}, {2'b10, 8'hff});
      put(2, CPL_CFG1_ADDR, 8'h7f);
      rd(1, CPL_CFG1_ADDR);
      check("config unused", v, 8'h3f);
      check("debug clock", dbg_clk_en, 1'b0);
      dbg(CPL_DBG_READ, 16'h0204, 8'h00);
      check("clock off read", r, 2'b01);
      // Write enable must ignore writes while interrupts are on
      mpu_int_en <= 1'b1;
      put(0, {8'h00, CPL_FLCTL_ADDR}, 8'h01);
      rd(0, {8'h00, CPL_FLCTL_ADDR});
      check("pwe inhibited", v[CPL_PWE_BIT], 1'b0);
      mpu_int_en <= 1'b0;
      put(2, CPL_CFG1_ADDR, 8'h00);
      @(posedge clk);
      dbg_port_en <= 1'b0;
      c = n[2];
      seq(CPL_FLCTL_ADDR, 8'h02, CPL_CMD_MASS);
      check("port off bulk", n[2] - c, 16'h0000);
      dbg_port_en <= 1'b1;
      seq(CPL_FLCTL_ADDR, 8'h02, CPL_CMD_MASS);
      check("port on bulk", n[2] - c, 16'h0001);
      $display("done clear");
   endtask
   initial
   begin
      reset_n = 1'b0;
      mpu_sfr_wr = '0;
      mpu_prog_wr = '0;
      cfg_wr = '0;
      dbg_req = '0;
      mpu_sfr_rd_addr = 8'h00;
      cfg_rd_addr = 16'h0000;
      dbg_port_en = 1'b1;
      mpu_int_en = 1'b0;
      do_reset();
      t_boot();
      t_open();
      t_lock();
      t_clear();
      tally_and_finish();
   end
endmodule // cpl_top_tb
bind cpl_top cpl_properties i_chk (.clk, .reset_n, .ce, .mpu_sfr_wr, .mpu_sfr_rd_addr, .mpu_sfr_rdata,
   .cfg_wr, .dbg_req, .dbg_port_en, .dbg_refused, .dbg_clk_en, .flash_cmd);

// [verilog/cpl_boot_window.sv]
// Boot window timer: flags the first cycles after reset release
`timescale 1ns/1ns
module cpl_boot_window
   import cpl_pkg::*;
(
   input logic clk,
   input logic reset_n,
   input logic ce,
   output logic boot_active
);

   typedef struct packed {
      logic [5:0] cnt;
      logic active;
   } cpl_boot_state_type;

   cpl_boot_state_type state_q;
   cpl_boot_state_type state_d;

   always_comb
   begin
      state_d = state_q;
      if (state_q.active)
      begin
         state_d.cnt = state_q.cnt + 6'h01;
         if (state_q.cnt == CPL_BOOT_CYCLES - 6'h01)
         begin
            state_d.active = 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_q <= '{cnt: 6'h00, active: 1'b1};
      end
      else if (ce)
      begin
         state_q <= state_d;
      end
   end

   assign boot_active = state_q.active;

endmodule // cpl_boot_window

// [verilog/cpl_erase_ctrl.sv]
// Flash erase command decoder with arm and page-select bookkeeping
`timescale 1ns/1ns
module cpl_erase_ctrl
   import cpl_pkg::*;
(
   input logic clk,
   input logic reset_n,
   input logic ce,
   input cpl_wr_type sfr_wr,
   input logic lock,
   input logic dbg_ok,
   output logic mass_go,
   output logic page_go,
   output logic [6:0] page
);

   typedef struct packed {
      logic arm;
      logic page_valid;
      logic [6:0] page_sel;
      logic mass;
      logic pg;
   } cpl_erase_state_type;

   cpl_erase_state_type state_q;
   cpl_erase_state_type state_d;

   always_comb
   begin
      state_d = state_q;
      state_d.mass = 1'b0;
      state_d.pg = 1'b0;
      if (sfr_wr.valid)
      begin
         if (sfr_wr.addr[7:0] == CPL_FLCTL_ADDR)
         begin
            state_d.arm = sfr_wr.data[CPL_ARM_BIT];
         end
         if (sfr_wr.addr[7:0] == CPL_PGSEL_ADDR)
         begin
            state_d.page_sel = sfr_wr.data[7:CPL_PGSEL_LSB];
            state_d.page_valid = 1'b1;
         end
         if (sfr_wr.addr[7:0] == CPL_ERASE_ADDR)
         begin
            // Arm and page select are single use
            if (sfr_wr.data == CPL_CMD_MASS && state_q.arm && dbg_ok)
            begin
               state_d.mass = 1'b1;
               state_d.arm = 1'b0;
            end
            if (sfr_wr.data == CPL_CMD_PAGE && state_q.page_valid)
            begin
               if (!(lock && state_q.page_sel == CPL_PAGE_ZERO))
               begin
                  state_d.pg = 1'b1;
                  state_d.page_valid = 1'b0;
               end
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_q <= '{arm: 1'b0, page_valid: 1'b0, page_sel: CPL_PGSEL_RESET, mass: 1'b0, pg: 1'b0};
      end
      else if (ce)
      begin
         state_q <= state_d;
      end
   end

   assign mass_go = state_q.mass;
   assign page_go = state_q.pg;
   assign page = state_q.page_sel;

endmodule // cpl_erase_ctrl

// [verilog/cpl_top.sv]
// Code protection lock: boot window, set-only lock, emulator gating
`timescale 1ns/1ns

// How it works
// - Locked emulator may only do bulk erase.
// - First 32 cycles hold the emulator off.
// - Control bit 7 reads high during boot.
// - After boot, emulator may act if permitted.
// - Lock bit clears on every reset.
// - Lock bit accepts ones only, never zero.
// - Lock stops all external flash reads.
// - Any reset unlocks; bulk erase alone does not.
// - Bulk erase also clears engine program RAM.
// - Locked: page zero page-erase is rejected.
// - Locked: byte writes to page zero blocked.
// - Debug clock off stops emulator clock.
// - Unused bits store nothing, read zero.
// - Configuration bits clear to zero at power-up.
// - 0xAA mass erase needs arm and debug port.
// - 0x55 erases the preselected page.
module cpl_top
   import cpl_pkg::*;
(
   input logic clk,
   input logic reset_n,
   input logic ce,
   input cpl_wr_type mpu_sfr_wr,
   input logic [7:0] mpu_sfr_rd_addr,
   output logic [7:0] mpu_sfr_rdata,
   input logic mpu_int_en,
   input cpl_wr_type mpu_prog_wr,
   input cpl_wr_type cfg_wr,
   input logic [15:0] cfg_rd_addr,
   output logic [7:0] cfg_rdata,
   input cpl_dbg_req_type dbg_req,
   input logic dbg_port_en,
   output logic dbg_ack,
   output logic dbg_refused,
   output logic [7:0] dbg_rdata,
   output logic dbg_clk_en,
   output cpl_flash_cmd_type flash_cmd,
   input logic [7:0] flash_rdata
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CPL_DS_IDLE,
      CPL_DS_ISSUE,
      CPL_DS_WAIT
   } cpl_dbg_state_type;

   typedef struct packed {
      logic lock;
      logic pwe;
      logic [7:0] cfg1;
      logic [7:0] sfr_rdata;
      logic [7:0] cfg_rdata;
      cpl_dbg_state_type dstate;
      logic ack;
      logic refused;
      logic [7:0] dbg_rdata;
      logic clk_en;
      cpl_flash_cmd_type fcmd;
   } cpl_top_state_type;

   cpl_top_state_type state_q;
   cpl_top_state_type state_d;

   logic boot;
   logic mass_go;
   logic page_go;
   logic [6:0] page;
   logic dclk_off;
   logic dbg_ok;
   logic dbg_lock_ok;
   logic dbg_take;
   cpl_wr_type sfr_wr;
   cpl_wr_type emu_sfr;

   // ------------------------------------------------------------
   // Sub-blocks
   // ------------------------------------------------------------
   cpl_boot_window u_boot (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .boot_active(boot)
   );

   cpl_erase_ctrl u_erase (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .sfr_wr(sfr_wr),
      .lock(state_q.lock),
      .dbg_ok(dbg_ok),
      .mass_go(mass_go),
      .page_go(page_go),
      .page(page)
   );

   // ------------------------------------------------------------
   // Emulator admission
   // ------------------------------------------------------------
   assign dclk_off = state_q.cfg1[CPL_DCLK_OFF_BIT];

   // Boot window and a stopped debug clock both shut the port
   assign dbg_ok = dbg_port_en && !boot && !dclk_off;

   // Under lock only the bulk erase sequence gets through
   assign dbg_lock_ok = dbg_req.op == CPL_DBG_SFR
      && ((dbg_req.addr[7:0] == CPL_ERASE_ADDR && dbg_req.data == CPL_CMD_MASS)
      || dbg_req.addr[7:0] == CPL_FLCTL_ADDR);

   always_comb
   begin
      dbg_take = 1'b0;
      if (dbg_req.valid && state_q.dstate == CPL_DS_IDLE && dbg_ok)
      begin
         dbg_take = !state_q.lock || dbg_lock_ok;
         // MPU wins any collision on the shared paths
         if (dbg_req.op == CPL_DBG_SFR && mpu_sfr_wr.valid)
         begin
            dbg_take = 1'b0;
         end
         if (dbg_req.op != CPL_DBG_SFR && mpu_prog_wr.valid)
         begin
            dbg_take = 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Merged control-register write path
   // ------------------------------------------------------------
   always_comb
   begin
      emu_sfr.valid = dbg_take && dbg_req.op == CPL_DBG_SFR;
      emu_sfr.addr = dbg_req.addr;
      emu_sfr.data = dbg_req.data;
      if (mpu_sfr_wr.valid)
      begin
         sfr_wr = mpu_sfr_wr;
      end
      else
      begin
         sfr_wr = emu_sfr;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;
      state_d.ack = 1'b0;
      state_d.refused = 1'b0;
      state_d.fcmd.rd = 1'b0;
      state_d.fcmd.wr = 1'b0;

      // Erase pulses from the decoder
      state_d.fcmd.page_erase = page_go;
      state_d.fcmd.mass_erase = mass_go;
      state_d.fcmd.engine_program_ram_clear = mass_go;
      state_d.fcmd.page = page;

      // Lock and write-enable bits
      if (sfr_wr.valid && sfr_wr.addr[7:0] == CPL_FLCTL_ADDR)
      begin
         if (sfr_wr.data[CPL_LOCK_BIT])
         begin
            state_d.lock = 1'b1;
         end
         // Locked emulator touches only the arm bit
         if (mpu_sfr_wr.valid && !mpu_int_en)
         begin
            state_d.pwe = sfr_wr.data[CPL_PWE_BIT];
         end
         else if (!mpu_sfr_wr.valid && !state_q.lock && !mpu_int_en)
         begin
            state_d.pwe = sfr_wr.data[CPL_PWE_BIT];
         end
      end

      // MPU byte write into program space
      if (mpu_prog_wr.valid && state_q.pwe)
      begin
         state_d.pwe = 1'b0;
         if (!(state_q.lock && mpu_prog_wr.addr[15:CPL_PAGE_LSB] == CPL_PAGE_ZERO))
         begin
            state_d.fcmd.wr = 1'b1;
            state_d.fcmd.addr = mpu_prog_wr.addr;
            state_d.fcmd.data = mpu_prog_wr.data;
         end
      end

      // Configuration register
      if (cfg_wr.valid && cfg_wr.addr == CPL_CFG1_ADDR)
      begin
         state_d.cfg1 = cfg_wr.data & CPL_CFG1_MASK;
      end
      state_d.clk_en = !state_d.cfg1[CPL_DCLK_OFF_BIT];

      // Read ports, one cycle latency
      state_d.sfr_rdata = 8'h00;
      if (mpu_sfr_rd_addr == CPL_FLCTL_ADDR)
      begin
         state_d.sfr_rdata[CPL_BOOT_BIT] = boot;
         state_d.sfr_rdata[CPL_LOCK_BIT] = state_q.lock;
         state_d.sfr_rdata[CPL_PWE_BIT] = state_q.pwe;
      end
      state_d.cfg_rdata = 8'h00;
      if (cfg_rd_addr == CPL_CFG1_ADDR)
      begin
         state_d.cfg_rdata = state_q.cfg1 & CPL_CFG1_MASK;
      end

      // Emulator sequencing
      unique case (state_q.dstate)
         CPL_DS_IDLE:
         begin
            if (dbg_req.valid && !dbg_take)
            begin
               state_d.refused = 1'b1;
            end
            else if (dbg_take)
            begin
               unique case (dbg_req.op)
                  CPL_DBG_READ:
                  begin
                     state_d.fcmd.rd = 1'b1;
                     state_d.fcmd.addr = dbg_req.addr;
                     state_d.dstate = CPL_DS_ISSUE;
                  end
                  CPL_DBG_WRITE:
                  begin
                     if (state_q.lock && dbg_req.addr[15:CPL_PAGE_LSB] == CPL_PAGE_ZERO)
                     begin
                        state_d.refused = 1'b1;
                     end
                     else
                     begin
                        state_d.fcmd.wr = 1'b1;
                        state_d.fcmd.addr = dbg_req.addr;
                        state_d.fcmd.data = dbg_req.data;
                        state_d.ack = 1'b1;
                     end
                  end
                  CPL_DBG_SFR:
                  begin
                     state_d.ack = 1'b1;
                  end
                  default:
                  begin
                     state_d.refused = 1'b1;
                  end
               endcase
            end
         end
         CPL_DS_ISSUE:
         begin
            state_d.refused = dbg_req.valid;
            state_d.dstate = CPL_DS_WAIT;
         end
         CPL_DS_WAIT:
         begin
            state_d.refused = dbg_req.valid;
            state_d.dbg_rdata = flash_rdata;
            state_d.ack = 1'b1;
            state_d.dstate = CPL_DS_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_q.lock <= 1'b0;
         state_q.pwe <= 1'b0;
         state_q.cfg1 <= CPL_CFG1_RESET;
         state_q.sfr_rdata <= 8'h00;
         state_q.cfg_rdata <= 8'h00;
         state_q.dstate <= CPL_DS_IDLE;
         state_q.ack <= 1'b0;
         state_q.refused <= 1'b0;
         state_q.dbg_rdata <= 8'h00;
         state_q.clk_en <= 1'b1;
         state_q.fcmd <= '0;
      end
      else if (ce)
      begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign mpu_sfr_rdata = state_q.sfr_rdata;
   assign cfg_rdata = state_q.cfg_rdata;
   assign dbg_ack = state_q.ack;
   assign dbg_refused = state_q.refused;
   assign dbg_rdata = state_q.dbg_rdata;
   assign dbg_clk_en = state_q.clk_en;
   assign flash_cmd = state_q.fcmd;

endmodule // cpl_top
